// [verilog/usbrd_pkg.sv]
// Package of constants and types for the redriver strap and flag logic
package usbrd_pkg;
    localparam logic [6:0] I2C_TARGET_ADDR = 7'h2C;
    localparam int         CLK_HZ          = 50_000_000;
    localparam int         CHIRP_MIN_NS    = 18_000;
    localparam int         CHIRP_MAX_NS    = 128_000;
    localparam int         CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
    // Least time rounds up, longest time rounds down
    localparam int         CHIRP_MIN_CYC   = (CHIRP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         CHIRP_MAX_CYC   = CHIRP_MAX_NS / CLK_PERIOD_NS;
    localparam int         CHIRP_CNT_W     = 13;

    // Three-level strap encodings
    localparam logic [1:0] TRI_LOW         = 2'h0;
    localparam logic [1:0] TRI_FLOAT       = 2'h1;
    localparam logic [1:0] TRI_HIGH        = 2'h2;

    // Dc_gain_strap settings in mV
    localparam logic [6:0] DC_GAIN_STRAP_40MV   = 7'h28;
    localparam logic [6:0] DC_GAIN_STRAP_60MV   = 7'h3C;
    localparam logic [6:0] DC_GAIN_STRAP_80MV   = 7'h50;

    localparam logic [1:0] AC_LEVEL_MAX    = 2'h3;
    localparam logic [6:0] DC_GAIN_STRAP_RST    = 7'h3C;

    typedef enum logic [2:0]
    {
        LS_DISCONN = 3'h0,
        LS_ATTACH  = 3'h1,
        LS_CHIRP_J = 3'h2,
        LS_CHIRP_K = 3'h3,
        LS_HS_WAIT = 3'h4,
        LS_HS      = 3'h5,
        LS_FIXTURE = 3'h6
    } usbrd_link_t;

    typedef struct packed
    {
        logic                   strap_done;
        logic                   i2c_mode;
        logic [1:0]             ac_level;
        logic [6:0]             dc_gain_strap_mv;
        usbrd_link_t            link;
        logic [CHIRP_CNT_W-1:0] chirp_cnt;
        logic                   attach_flag;
        logic                   hs_flag;
        logic [1:0]             rst_sync;
        logic [7:0]             ev_sync1;
        logic [7:0]             ev_sync2;
        logic [6:0]             strap_sync1;
        logic [6:0]             strap_sync2;
    } usbrd_state_t;
endpackage

// [verilog/usbrd_strap_flags.sv]
// Strap capture and status flag logic of the redriver
// Contract
// - While the reset input is low the device is held in reset and shutdown, else it runs.
// - Both I2C lines high at reset select I2C mode, otherwise pin-strap mode.
// - In I2C mode the shared clock pin is the I2C clock and the target address is 0x2C.
// - In pin-strap mode the clock pin becomes the attach flag, set on a data-line pull-up.
// - The attach flag clears when a disconnect is detected.
// - The AC boost strap is sampled only at reset release and held until the next reset.
// - A floating AC boost strap selects the maximum AC boost.
// - In pin-strap mode the DC strap selects 80 mV high, 60 mV floating, 40 mV low.
// - In I2C mode the DC pin is neither a boost strap nor a status output.
// - In pin-strap mode the DC pin becomes the high-speed-active output after reset.
// - High-speed flag sets on a test fixture from unconnected followed by a test packet.
// - High-speed flag sets on squelch after a USB reset with one J/K chirp pair of 18-128 us.
// - The core regulator is enabled only while the channel is in high-speed mode.
// - The AC boost strap decodes into levels 0 to 3 from the pull-down value.
module usbrd_strap_flags
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    // Device reset pin
    input  wire logic       active_low_device_reset,
    // Straps, analog-decoded
    input  wire logic       scl_pulled_high,
    input  wire logic       sda_pulled_high,
    input  wire logic [1:0] ac_boost_strap,
    input  wire logic       ac_boost_floating,
    input  wire logic [1:0] dc_gain_strap,
    // Line events from the analog front end
    input  wire logic       pullup_seen,
    input  wire logic       disconnect_seen,
    input  wire logic       usb_reset_seen,
    input  wire logic       chirp_j_active,
    input  wire logic       chirp_k_active,
    input  wire logic       squelch_seen,
    input  wire logic       fixture_seen,
    input  wire logic       test_packet_seen,
    // Configuration results
    output logic            device_enable,
    output logic            i2c_mode,
    output logic [6:0]      i2c_target_addr,
    output logic [1:0]      ac_boost_level,
    output logic [6:0]      dc_gain_strap_mv,
    // Shared pin drive
    output logic            attach_detected_flag,
    output logic            attach_detected_oe,
    output logic            high_speed_active_flag,
    output logic            high_speed_active_oe,
    output logic            core_regulator_output
);
    usbrd_pkg::usbrd_state_t st_r;
    usbrd_pkg::usbrd_state_t st_nxt;
    logic                    run;
    logic                    pull;
    logic                    disc;
    logic                    ureset;
    logic                    cj;
    logic                    ck;
    logic                    squelch;
    logic                    fixture;
    logic                    tpkt;
    logic                    chirp_ok;
    logic                    strap_i2c;

    // Counter must reach the longest legal chirp
    if (usbrd_pkg::CHIRP_MAX_CYC >= (1 << usbrd_pkg::CHIRP_CNT_W))
    begin
        $error("chirp counter too narrow");
    end

    // Straps are pins: read only after two flip-flops
    assign strap_i2c = st_r.strap_sync2[6] && st_r.strap_sync2[5];
    assign run      = st_r.rst_sync[1];
    assign pull     = st_r.ev_sync2[0];
    assign disc     = st_r.ev_sync2[1];
    assign ureset   = st_r.ev_sync2[2];
    assign cj       = st_r.ev_sync2[3];
    assign ck       = st_r.ev_sync2[4];
    assign squelch  = st_r.ev_sync2[5];
    assign fixture  = st_r.ev_sync2[6];
    assign tpkt     = st_r.ev_sync2[7];
    assign chirp_ok = (st_r.chirp_cnt >= usbrd_pkg::CHIRP_CNT_W'(usbrd_pkg::CHIRP_MIN_CYC))
                   && (st_r.chirp_cnt <= usbrd_pkg::CHIRP_CNT_W'(usbrd_pkg::CHIRP_MAX_CYC));

    always_comb
    begin
        st_nxt          = st_r;
        st_nxt.rst_sync = {st_r.rst_sync[0], active_low_device_reset};
        st_nxt.ev_sync1 = {test_packet_seen, fixture_seen, squelch_seen, chirp_k_active,
                           chirp_j_active, usb_reset_seen, disconnect_seen, pullup_seen};
        st_nxt.ev_sync2 = st_r.ev_sync1;
        st_nxt.strap_sync1 = {scl_pulled_high, sda_pulled_high, ac_boost_floating,
                              ac_boost_strap, dc_gain_strap};
        st_nxt.strap_sync2 = st_r.strap_sync1;
        if (!run)
        begin
            // Held in reset and shutdown; straps recaptured at next release
            st_nxt.strap_done  = 1'b0;
            st_nxt.link        = usbrd_pkg::LS_DISCONN;
            st_nxt.chirp_cnt   = '0;
            st_nxt.attach_flag = 1'b0;
            st_nxt.hs_flag     = 1'b0;
        end
        else if (!st_r.strap_done)
        begin
            // Single capture of all straps at release
            st_nxt.strap_done  = 1'b1;
            st_nxt.i2c_mode    = strap_i2c;
            st_nxt.ac_level    = st_r.strap_sync2[4] ? usbrd_pkg::AC_LEVEL_MAX
                                                     : st_r.strap_sync2[3:2];
            // DC pin is a test pin in I2C mode, so its strap is not used
            st_nxt.dc_gain_strap_mv = usbrd_pkg::DC_GAIN_STRAP_RST;
            if (!strap_i2c)
            begin
                unique case (st_r.strap_sync2[1:0])
                    usbrd_pkg::TRI_HIGH:  st_nxt.dc_gain_strap_mv = usbrd_pkg::DC_GAIN_STRAP_80MV;
                    usbrd_pkg::TRI_LOW:   st_nxt.dc_gain_strap_mv = usbrd_pkg::DC_GAIN_STRAP_40MV;
                    default:              st_nxt.dc_gain_strap_mv = usbrd_pkg::DC_GAIN_STRAP_60MV;
                endcase
            end
        end
        else
        begin
            if (disc)
            begin
                st_nxt.attach_flag = 1'b0;
                st_nxt.hs_flag     = 1'b0;
                st_nxt.link        = usbrd_pkg::LS_DISCONN;
            end
            else
            begin
                if (st_r.link == usbrd_pkg::LS_DISCONN && pull)
                    st_nxt.attach_flag = 1'b1;
                unique case (st_r.link)
                    usbrd_pkg::LS_DISCONN:
                    begin
                        if (fixture)
                            st_nxt.link = usbrd_pkg::LS_FIXTURE;
                        else if (pull)
                            st_nxt.link = usbrd_pkg::LS_ATTACH;
                    end
                    usbrd_pkg::LS_FIXTURE:
                    begin
                        if (tpkt)
                        begin
                            st_nxt.hs_flag = 1'b1;
                            st_nxt.link    = usbrd_pkg::LS_HS;
                        end
                    end
                    usbrd_pkg::LS_ATTACH:
                    begin
                        st_nxt.chirp_cnt = '0;
                        // Entry cycle already counts as the first chirp cycle
                        if (ureset && cj)
                        begin
                            st_nxt.chirp_cnt = usbrd_pkg::CHIRP_CNT_W'(1);
                            st_nxt.link      = usbrd_pkg::LS_CHIRP_J;
                        end
                    end
                    usbrd_pkg::LS_CHIRP_J:
                    begin
                        if (cj)
                        begin
                            if (st_r.chirp_cnt != '1)
                                st_nxt.chirp_cnt = st_r.chirp_cnt + 1'b1;
                        end
                        else if (ck && chirp_ok)
                        begin
                            st_nxt.chirp_cnt = usbrd_pkg::CHIRP_CNT_W'(1);
                            st_nxt.link      = usbrd_pkg::LS_CHIRP_K;
                        end
                        else
                            st_nxt.link = usbrd_pkg::LS_ATTACH;
                    end
                    usbrd_pkg::LS_CHIRP_K:
                    begin
                        if (ck)
                        begin
                            if (st_r.chirp_cnt != '1)
                                st_nxt.chirp_cnt = st_r.chirp_cnt + 1'b1;
                        end
                        else if (chirp_ok)
                            st_nxt.link = usbrd_pkg::LS_HS_WAIT;
                        else
                            st_nxt.link = usbrd_pkg::LS_ATTACH;
                    end
                    usbrd_pkg::LS_HS_WAIT:
                    begin
                        if (squelch)
                        begin
                            st_nxt.hs_flag = 1'b1;
                            st_nxt.link    = usbrd_pkg::LS_HS;
                        end
                    end
                    usbrd_pkg::LS_HS:
                    begin
                        if (ureset)
                        begin
                            // A new chirp J is timed from this cycle on
                            st_nxt.hs_flag   = 1'b0;
                            st_nxt.chirp_cnt = usbrd_pkg::CHIRP_CNT_W'(1);
                            st_nxt.link      = cj ? usbrd_pkg::LS_CHIRP_J : usbrd_pkg::LS_ATTACH;
                        end
                    end
                    default:
                        st_nxt.link = usbrd_pkg::LS_DISCONN;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_r             <= '0;
            st_r.ac_level    <= usbrd_pkg::AC_LEVEL_MAX;
            st_r.dc_gain_strap_mv <= usbrd_pkg::DC_GAIN_STRAP_RST;
        end
        else
            st_r <= st_nxt;
    end

    assign device_enable          = run && st_r.strap_done;
    assign i2c_mode               = st_r.i2c_mode;
    assign i2c_target_addr        = usbrd_pkg::I2C_TARGET_ADDR;
    assign ac_boost_level         = st_r.ac_level;
    assign dc_gain_strap_mv            = st_r.dc_gain_strap_mv;
    // Status pins driven only in pin-strap mode after capture
    assign attach_detected_oe     = device_enable && !st_r.i2c_mode;
    assign attach_detected_flag   = st_r.attach_flag && attach_detected_oe;
    assign high_speed_active_oe   = device_enable && !st_r.i2c_mode;
    assign high_speed_active_flag = st_r.hs_flag && high_speed_active_oe;
    assign core_regulator_output  = device_enable && st_r.hs_flag;
endmodule

// [verif/usbrd_chk.sv]
// Assertion checker for the redriver strap and flag logic
module usbrd_chk
(
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       reset_n,
    // Watched inputs
    input wire logic       active_low_device_reset,
    input wire logic       pullup_seen,
    input wire logic       disconnect_seen,
    input wire logic       squelch_seen,
    input wire logic       test_packet_seen,
    // Watched outputs
    input wire logic       device_enable,
    input wire logic       i2c_mode,
    input wire logic [6:0] i2c_target_addr,
    input wire logic [1:0] ac_boost_level,
    input wire logic [6:0] dc_gain_strap_mv,
    input wire logic       attach_detected_flag,
    input wire logic       attach_detected_oe,
    input wire logic       high_speed_active_flag,
    input wire logic       high_speed_active_oe,
    input wire logic       core_regulator_output
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    chk_pin_reset_off: assert property (!active_low_device_reset [*4] |-> !device_enable)
        else $error("device still enabled under pin reset");
    chk_target_addr: assert property (i2c_target_addr == 7'h2C)
        else $error("wrong target address");
    chk_oe_by_mode: assert property ((attach_detected_oe == (device_enable && !i2c_mode))
        && (high_speed_active_oe == attach_detected_oe))
        else $error("status drive does not follow mode");
    chk_attach_cause: assert property ($rose(attach_detected_flag) |-> $past(pullup_seen, 3))
        else $error("attach flag rose without pull-up");
    chk_attach_clear: assert property (attach_detected_flag && disconnect_seen
        |-> ##3 !attach_detected_flag)
        else $error("attach flag kept after disconnect");
    chk_straps_held: assert property (device_enable && $past(device_enable) |-> $stable(i2c_mode)
        && $stable(ac_boost_level) && $stable(dc_gain_strap_mv))
        else $error("strap setting changed while running");
    chk_dc_legal: assert property (!i2c_mode |-> dc_gain_strap_mv inside {7'h28, 7'h3C, 7'h50})
        else $error("illegal Dc_gain_strap");
    chk_i2c_dc_fixed: assert property (i2c_mode |-> dc_gain_strap_mv == 7'h3C)
        else $error("Dc_gain_strap taken from strap in I2C mode");
    chk_hs_cause: assert property ($rose(high_speed_active_flag)
        |-> $past(squelch_seen, 3) || $past(test_packet_seen, 3))
        else $error("high-speed flag rose without cause");
    chk_hs_clear: assert property (high_speed_active_flag && disconnect_seen
        |-> ##3 !high_speed_active_flag)
        else $error("high-speed flag kept after disconnect");
    chk_reg_with_hs: assert property (high_speed_active_flag
        |-> core_regulator_output && device_enable)
        else $error("regulator off in high-speed mode");
endmodule
bind usbrd_strap_flags usbrd_chk usbrd_chk_i (.clk_sys, .reset_n, .active_low_device_reset,
    .pullup_seen, .disconnect_seen, .squelch_seen, .test_packet_seen, .device_enable, .i2c_mode,
    .i2c_target_addr, .ac_boost_level, .dc_gain_strap_mv, .attach_detected_flag, .attach_detected_oe,
    .high_speed_active_flag, .high_speed_active_oe, .core_regulator_output);

// [verif/usbrd_line_model.sv]
// Line event model for the host and device on the conditioned lines
module usbrd_line_model
(
    // Clock
    input  wire logic clk_sys,
    // Line events
    output logic      pullup_seen = 1'b0,
    output logic      disconnect_seen = 1'b0,
    output logic      usb_reset_seen = 1'b0,
    output logic      chirp_j_active = 1'b0,
    output logic      chirp_k_active = 1'b0,
    output logic      squelch_seen = 1'b0,
    output logic      fixture_seen = 1'b0,
    output logic      test_packet_seen = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic attach();
        @(posedge clk_sys);
        pullup_seen <= 1'b1;
    endtask
    task automatic detach();
        @(posedge clk_sys);
        pullup_seen <= 1'b0;
        disconnect_seen <= 1'b1;
        repeat (4) @(posedge clk_sys);
        disconnect_seen <= 1'b0;
    endtask
    // USB reset with chirp J, then chirp K, then squelch
    task automatic handshake(int j_cyc, int k_cyc);
        @(posedge clk_sys);
        usb_reset_seen <= 1'b1;
        chirp_j_active <= 1'b1;
        repeat (j_cyc) @(posedge clk_sys);
        usb_reset_seen <= 1'b0;
        chirp_j_active <= 1'b0;
        chirp_k_active <= 1'b1;
        repeat (k_cyc) @(posedge clk_sys);
        chirp_k_active <= 1'b0;
        squelch_seen <= 1'b1;
        repeat (4) @(posedge clk_sys);
        squelch_seen <= 1'b0;
    endtask
    task automatic fixture();
        @(posedge clk_sys);
        fixture_seen <= 1'b1;
        repeat (4) @(posedge clk_sys);
        fixture_seen <= 1'b0;
        test_packet_seen <= 1'b1;
        repeat (4) @(posedge clk_sys);
        test_packet_seen <= 1'b0;
    endtask
endmodule

// [verif/test_usbrd_strap_flags.sv]
// Testbench of the redriver strap and flag logic
module test_usbrd_strap_flags;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_sys = 1'b0;
    logic       reset_n = 1'b0;
    logic       active_low_device_reset = 1'b0;
    logic       scl_pulled_high = 1'b0;
    logic       sda_pulled_high = 1'b0;
    logic       ac_boost_floating = 1'b0;
    logic [1:0] ac_boost_strap = 2'h0;
    logic [1:0] dc_gain_strap = 2'h0;
    logic       pullup_seen, disconnect_seen, usb_reset_seen, chirp_j_active, chirp_k_active;
    logic       squelch_seen, fixture_seen, test_packet_seen, device_enable, i2c_mode;
    logic       attach_detected_flag, attach_detected_oe, high_speed_active_flag;
    logic       high_speed_active_oe, core_regulator_output;
    logic [1:0] ac_boost_level;
    logic [6:0] i2c_target_addr, dc_gain_strap_mv;
    int         miscompares = 0;
    int         total_checks = 0;
    usbrd_strap_flags usbrd_strap_flags_i (.clk_sys, .reset_n, .active_low_device_reset,
        .scl_pulled_high, .sda_pulled_high, .ac_boost_strap, .ac_boost_floating, .dc_gain_strap,
        .pullup_seen, .disconnect_seen, .usb_reset_seen, .chirp_j_active, .chirp_k_active,
        .squelch_seen, .fixture_seen, .test_packet_seen, .device_enable, .i2c_mode,
        .i2c_target_addr, .ac_boost_level, .dc_gain_strap_mv, .attach_detected_flag,
        .attach_detected_oe, .high_speed_active_flag, .high_speed_active_oe, .core_regulator_output);
    usbrd_line_model usbrd_line_model_i (.clk_sys, .pullup_seen, .disconnect_seen,
        .usb_reset_seen, .chirp_j_active, .chirp_k_active, .squelch_seen, .fixture_seen,
        .test_packet_seen);
    always #10 clk_sys = ~clk_sys;
    task automatic cmp(logic [6:0] seen, logic [6:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        if (miscompares == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic hs_is(logic e);
        @(negedge clk_sys);
        cmp(high_speed_active_flag, e);
        cmp(core_regulator_output, e);
    endtask
    // Pin reset with given straps, then move the AC and DC straps to prove they are ignored
    task automatic cfg(logic scl, logic sda, logic [1:0] ac, logic acf, logic [1:0] dc,
                       logic ei, logic [1:0] ea, logic [6:0] ed);
        @(posedge clk_sys);
        active_low_device_reset <= 1'b0;
        {scl_pulled_high, sda_pulled_high, ac_boost_strap, ac_boost_floating} <= {scl, sda, ac, acf};
        dc_gain_strap <= dc;
        repeat (6) @(posedge clk_sys);
        active_low_device_reset <= 1'b1;
        repeat (6) @(posedge clk_sys);
        {ac_boost_strap, ac_boost_floating, dc_gain_strap} <= {~ac, ~acf, ~dc};
        repeat (3) @(negedge clk_sys);
        cmp(device_enable, 1'b1);
        cmp(i2c_mode, ei);
        cmp(ac_boost_level, ea);
        cmp(dc_gain_strap_mv, ed);
        if (ei) cmp(i2c_target_addr, 7'h2C);
        cmp(attach_detected_oe, !ei);
        cmp(high_speed_active_oe, !ei);
    endtask
    initial
    begin
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        cfg(1'b1, 1'b1, 2'h2, 1'b0, 2'h0, 1'b1, 2'h2, 7'h3C);
        cfg(1'b0, 1'b0, 2'h0, 1'b0, 2'h0, 1'b0, 2'h0, 7'h28);
        cfg(1'b1, 1'b0, 2'h1, 1'b0, 2'h3, 1'b0, 2'h1, 7'h3C);
        cfg(1'b0, 1'b1, 2'h2, 1'b0, 2'h2, 1'b0, 2'h2, 7'h50);
        cfg(1'b0, 1'b0, 2'h0, 1'b1, 2'h1, 1'b0, 2'h3, 7'h3C);
        usbrd_line_model_i.attach();
        repeat (6) @(negedge clk_sys);
        cmp(attach_detected_flag, 1'b1);
        usbrd_line_model_i.handshake(1000, 1000);
        hs_is(1'b1);
        usbrd_line_model_i.handshake(100, 1000);
        hs_is(1'b0);
        usbrd_line_model_i.handshake(899, 1000);
        hs_is(1'b0);
        usbrd_line_model_i.handshake(1000, 6401);
        hs_is(1'b0);
        usbrd_line_model_i.handshake(1000, 1000);
        hs_is(1'b1);
        usbrd_line_model_i.handshake(900, 6400);
        hs_is(1'b1);
        usbrd_line_model_i.detach();
        repeat (2) @(negedge clk_sys);
        cmp(attach_detected_flag, 1'b0);
        hs_is(1'b0);
        usbrd_line_model_i.fixture();
        hs_is(1'b1);
        @(posedge clk_sys);
        active_low_device_reset <= 1'b0;
        repeat (5) @(negedge clk_sys);
        cmp(device_enable, 1'b0);
        hs_is(1'b0);
        wrap_up();
    end
    initial
    begin
        #800_000;
        miscompares++;
        wrap_up();
    end
endmodule
